// *** design/dsc_params.svh ***
// Timing counts and field positions for the disk serial command link.
// Assumes inclusion by both ends; the package does not include it.
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
`define DSC_CMD_BITS        17
`define DSC_FUNC_HI         15
`define DSC_FUNC_LO         12
`define DSC_MOD_HI          11
`define DSC_MOD_LO          8
`define DSC_GROUP_HI        7
`define DSC_GROUP_LO        4
`define DSC_PARAM_HI        11
`define DSC_SPLICE_CYC      4
`define DSC_OFFSET_RST      4'h0
`endif

// *** design/dsc_pkg.sv ***
// Types shared by both ends of the disk serial command link.
// Assumes dsc_params.svh is on the include path.
package dsc_pkg;
  typedef enum logic [3:0] {
    DSC_FN_SEEK   = 4'h0,
    DSC_FN_RECAL  = 4'h1,
    DSC_FN_STAT   = 4'h2,
    DSC_FN_CONF   = 4'h3,
    DSC_FN_GROUP  = 4'h4,
    DSC_FN_CTRL   = 4'h5,
    DSC_FN_STROBE = 4'h6,
    DSC_FN_TRACK  = 4'h7,
    DSC_FN_SELF   = 4'h8,
    DSC_FN_SECSZ  = 4'h9
  } dsc_func_e;

  typedef enum logic [3:0] {
    DSC_ST_IDLE = 4'b0001,
    DSC_ST_BIT  = 4'b0010,
    DSC_ST_WAIT = 4'b0100,
    DSC_ST_DONE = 4'b1000
  } dsc_state_e;

  // Odd parity bit for a 16-bit command word.
  function automatic logic dsc_odd_par(input logic [15:0] w);
    dsc_odd_par = ~(^w);
  endfunction
endpackage

// *** design/dsc_link_if.sv ***
// Control-cable lines between host controller and drive, active low.
// Assumes both ends share ref_clk_i; the bench joins the modports.
`timescale 1ns/1ps
interface dsc_link_if;
  logic [3:0] head_sel_n;
  logic       wr_en_n;
  logic       rd_en_n;
  logic       cmd_data_n;
  logic       xfer_req_n;
  logic       xfer_ack_n;
  logic       op_done_n;
  modport drive (input  head_sel_n, wr_en_n, rd_en_n, cmd_data_n,
                 input  xfer_req_n,
                 output xfer_ack_n, op_done_n);
  modport host  (output head_sel_n, wr_en_n, rd_en_n, cmd_data_n,
                 output xfer_req_n,
                 input  xfer_ack_n, op_done_n);
endinterface

// *** design/dsc_host.sv ***
// Host end: shifts a command word out and drives head and gate lines.
// Assumes link lines come from the drive end, which may be asynchronous.
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_host
  import dsc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [15:0] cmd_word_i,
  input  wire logic [3:0]  head_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic             cmd_busy_o,
  output logic             cmd_done_o,
  dsc_link_if.host         link
);
  logic [16:0] shift_r;
  logic [4:0]  cnt_r;
  logic [1:0]  ack_sync_r;
  logic [1:0]  done_sync_r;
  logic        data_r;
  logic        req_r;
  logic [3:0]  head_r;
  logic        wr_r;
  logic        rd_r;
  dsc_state_e  state_r;

  assign link.cmd_data_n = ~data_r;
  assign link.xfer_req_n = ~req_r;
  assign link.head_sel_n = ~head_r;
  assign link.wr_en_n    = ~wr_r;
  assign link.rd_en_n    = ~rd_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_sync_r  <= 2'h0;
      done_sync_r <= 2'h0;
    end else if (clk_en_i) begin
      ack_sync_r  <= {ack_sync_r[0], ~link.xfer_ack_n};
      done_sync_r <= {done_sync_r[0], ~link.op_done_n};
    end
  end

  // Gates and head lines are plain registered copies of the user inputs.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head_r <= 4'h0;
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
    end else if (clk_en_i) begin
      head_r <= head_i;
      wr_r   <= wr_en_i;
      rd_r   <= rd_en_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r    <= DSC_ST_IDLE;
      shift_r    <= 17'h00000;
      cnt_r      <= 5'h00;
      data_r     <= 1'b0;
      req_r      <= 1'b0;
      cmd_busy_o <= 1'b0;
      cmd_done_o <= 1'b0;
    end else if (clk_en_i) begin
      cmd_done_o <= 1'b0;
      case (state_r)
        DSC_ST_IDLE: begin
          data_r <= 1'b0;
          if (cmd_valid_i && done_sync_r[1]) begin
            shift_r    <= {cmd_word_i, dsc_odd_par(cmd_word_i)};
            cnt_r      <= 5'(`DSC_CMD_BITS);
            cmd_busy_o <= 1'b1;
            state_r    <= DSC_ST_BIT;
          end
        end
        DSC_ST_BIT: begin
          if (!ack_sync_r[1]) begin
            data_r  <= shift_r[16];
            shift_r <= {shift_r[15:0], 1'b0};
            req_r   <= 1'b1;
            cnt_r   <= cnt_r - 5'h01;
            state_r <= DSC_ST_WAIT;
          end
        end
        DSC_ST_WAIT: begin
          if (ack_sync_r[1]) begin
            req_r   <= 1'b0;
            state_r <= (cnt_r == 5'h00) ? DSC_ST_DONE : DSC_ST_BIT;
          end
        end
        DSC_ST_DONE: begin
          if (!ack_sync_r[1]) begin
            data_r     <= 1'b0;
            cmd_busy_o <= 1'b0;
            cmd_done_o <= 1'b1;
            state_r    <= DSC_ST_IDLE;
          end
        end
        default: state_r <= DSC_ST_IDLE;
      endcase
    end
  end
endmodule

// *** design/dsc_drive.sv ***
// Drive end: head decode, write/read gating and serial command decode.
// Assumes host lines arrive asynchronously; each passes two flops.
//
// What this block does
// - Head lines decode as binary head 0-15.
// - All head lines inactive selects head 0 while group_r is zero.
// - Head group command extends head number.
// - Heads number across removable then fixed media.
// - Writing to a missing head raises fault.
// - Write only while write gate low.
// - Write gate falling edge pulses splice_o for one cycle.
// - Host gaps write gate two bits formatting; dsc_host passes wr_en_i through ungapped.
// - Read data delivered only while read gate low.
// - Host asserts read gate inside preamble only; dsc_host passes rd_en_i through untimed.
// - Host keeps read gate off over splices; dsc_host does not gate rd_en_i by wr_en_i.
// - Sixteen bits plus parity per command, one bit per handshake.
// - Bits shift MSB first, parity last.
// - Drive executes the received command.
// - Parity is odd over the whole word.
// - Host starts only while operation done.
// - Host holds command line high when idle.
// - Function high nibble; unused low bits zero.
// - Decode control, offsets, self check, sector size.
// - Reserved function or modifier is invalid.
// - Strobe and track offsets held independently.
// - Seek moves to cylinder, clears offsets.
// - Recalibrate returns to zero, clears offsets.
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_drive
  import dsc_pkg::*;
#(
  parameter int          HEAD_GROUP_W = 4,
  parameter logic [7:0]  HEADS_FITTED = 8'h10,
  parameter logic        REMOVABLE    = 1'b0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         clk_en_i,
  input  wire logic         busy_i,
  input  wire logic         media_rd_i,
  dsc_link_if.drive         link,
  output logic [7:0]        head_o,
  output logic              head_removable_o,
  output logic              write_on_o,
  output logic              splice_o,
  output logic              read_on_o,
  output logic              rd_data_o,
  output logic              write_fault_o,
  output logic [11:0]       cylinder_o,
  output logic              seek_o,
  output logic              recal_o,
  output logic [3:0]        strobe_off_o,
  output logic [3:0]        track_off_o,
  output logic [3:0]        ctrl_op_o,
  output logic              ctrl_o,
  output logic              self_check_cmd_o,
  output logic              sector_size_cmd_o,
  output logic [11:0]       sector_size_o,
  output logic              invalid_o
);
  logic [1:0]  hs_sync_r [4];
  logic [1:0]  wr_sync_r;
  logic [1:0]  rd_sync_r;
  logic [1:0]  cd_sync_r;
  logic [1:0]  rq_sync_r;
  logic        wr_prev_r;
  logic [HEAD_GROUP_W-1:0] group_r;
  logic [16:0] rx_r;
  logic [4:0]  cnt_r;
  logic        ack_r;
  logic        busy_r;
  logic        word_r;
  logic [7:0]  head_nxt;
  logic [15:0] w;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_hs
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) hs_sync_r[g] <= 2'h0;
        else if (clk_en_i)
          hs_sync_r[g] <= {hs_sync_r[g][0], ~link.head_sel_n[g]};
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_sync_r <= 2'h0;
      rd_sync_r <= 2'h0;
      cd_sync_r <= 2'h0;
      rq_sync_r <= 2'h0;
    end else if (clk_en_i) begin
      wr_sync_r <= {wr_sync_r[0], ~link.wr_en_n};
      rd_sync_r <= {rd_sync_r[0], ~link.rd_en_n};
      cd_sync_r <= {cd_sync_r[0], ~link.cmd_data_n};
      rq_sync_r <= {rq_sync_r[0], ~link.xfer_req_n};
    end
  end

  // Inactive-high lines invert to zero, so all-high lands on head 0 while group_r is zero.
  always_comb begin
    head_nxt = 8'h00;
    head_nxt[3:0] = {hs_sync_r[3][1], hs_sync_r[2][1],
                     hs_sync_r[1][1], hs_sync_r[0][1]};
    head_nxt[HEAD_GROUP_W+3:4] = group_r;
  end

  // Strobes are registered from synchronised gates.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head_o           <= 8'h00;
      head_removable_o <= 1'b0;
      write_on_o       <= 1'b0;
      splice_o         <= 1'b0;
      wr_prev_r        <= 1'b0;
      read_on_o        <= 1'b0;
      rd_data_o        <= 1'b0;
      write_fault_o    <= 1'b0;
    end else if (clk_en_i) begin
      head_o           <= head_nxt;
      head_removable_o <= REMOVABLE && (head_nxt == 8'h00);
      write_on_o       <= wr_sync_r[1];
      wr_prev_r        <= wr_sync_r[1];
      splice_o         <= wr_sync_r[1] && !wr_prev_r;
      read_on_o        <= rd_sync_r[1];
      rd_data_o        <= rd_sync_r[1] && media_rd_i;
      if (wr_sync_r[1] && head_nxt >= HEADS_FITTED)
        write_fault_o <= 1'b1;
      else if (!wr_sync_r[1]) write_fault_o <= 1'b0;
    end
  end

  // Receive one bit per request; ack follows request.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_r   <= 17'h00000;
      cnt_r  <= 5'h00;
      ack_r  <= 1'b0;
      word_r <= 1'b0;
    end else if (clk_en_i) begin
      word_r <= 1'b0;
      if (rq_sync_r[1] && !ack_r) begin
        ack_r <= 1'b1;
        rx_r  <= {rx_r[15:0], cd_sync_r[1]};
        if (cnt_r == 5'(`DSC_CMD_BITS - 1)) begin
          cnt_r  <= 5'h00;
          word_r <= 1'b1;
        end else cnt_r <= cnt_r + 5'h01;
      end else if (!rq_sync_r[1]) ack_r <= 1'b0;
    end
  end

  assign link.xfer_ack_n = ~ack_r;
  assign link.op_done_n  = busy_r;
  assign w = rx_r[16:1];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) busy_r <= 1'b0;
    else if (clk_en_i) busy_r <= busy_i;
  end

  // Decode of a complete word; bad parity only raises invalid_o.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      group_r <= '0;
      cylinder_o <= 12'h000;
      seek_o <= 1'b0;
      recal_o <= 1'b0;
      strobe_off_o <= `DSC_OFFSET_RST;
      track_off_o <= `DSC_OFFSET_RST;
      ctrl_op_o <= 4'h0;
      ctrl_o <= 1'b0;
      self_check_cmd_o <= 1'b0;
      sector_size_cmd_o <= 1'b0;
      sector_size_o <= 12'h000;
      invalid_o <= 1'b0;
    end else if (clk_en_i) begin
      {seek_o, recal_o, ctrl_o, self_check_cmd_o} <= 4'h0;
      sector_size_cmd_o <= 1'b0;
      invalid_o <= 1'b0;
      if (word_r) begin
        if (rx_r[0] != dsc_odd_par(w)) invalid_o <= 1'b1;
        else case (w[`DSC_FUNC_HI:`DSC_FUNC_LO])
          DSC_FN_SEEK: begin
            cylinder_o <= w[`DSC_PARAM_HI:0];
            seek_o <= 1'b1;
            strobe_off_o <= `DSC_OFFSET_RST;
            track_off_o <= `DSC_OFFSET_RST;
          end
          DSC_FN_RECAL: begin
            cylinder_o <= 12'h000;
            recal_o <= 1'b1;
            strobe_off_o <= `DSC_OFFSET_RST;
            track_off_o <= `DSC_OFFSET_RST;
          end
          DSC_FN_STAT, DSC_FN_CONF: ;
          DSC_FN_GROUP: group_r <=
              w[`DSC_GROUP_LO+HEAD_GROUP_W-1:`DSC_GROUP_LO];
          DSC_FN_CTRL: begin
            if (w[11] || w[10] || w[`DSC_MOD_HI:`DSC_MOD_LO] == 4'h1)
              invalid_o <= 1'b1;
            else begin
              ctrl_op_o <= w[`DSC_MOD_HI:`DSC_MOD_LO];
              ctrl_o <= 1'b1;
            end
          end
          DSC_FN_STROBE: begin
            if (w[11]) invalid_o <= 1'b1;
            else strobe_off_o <= w[`DSC_MOD_HI:`DSC_MOD_LO];
          end
          DSC_FN_TRACK: begin
            if (w[11]) invalid_o <= 1'b1;
            else track_off_o <= w[`DSC_MOD_HI:`DSC_MOD_LO];
          end
          DSC_FN_SELF: self_check_cmd_o <= 1'b1;
          DSC_FN_SECSZ: begin
            sector_size_o <= w[`DSC_PARAM_HI:0];
            sector_size_cmd_o <= 1'b1;
          end
          default: invalid_o <= 1'b1;
        endcase
      end
    end
  end
endmodule

// *** tb/dsc_link_properties.sv ***
// Checker for the command handshake on the control-cable lines.
// Assumes it sees the shared interface lines on the common clock.
`timescale 1ns/1ps
module dsc_link_properties (
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  input wire logic [3:0] head_sel_n,
  input wire logic       wr_en_n,
  input wire logic       rd_en_n,
  input wire logic       cmd_data_n,
  input wire logic       xfer_req_n,
  input wire logic       xfer_ack_n,
  input wire logic       op_done_n
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  ack_follows_req_a: assert property (
    $fell(xfer_req_n) |-> ##[1:6] !xfer_ack_n) else $error("ack late");
  ack_released_a: assert property (
    $rose(xfer_req_n) |-> ##[1:6] xfer_ack_n) else $error("ack stuck");
  bit_held_a: assert property (
    !xfer_req_n && !$fell(xfer_req_n) |-> $stable(cmd_data_n))
    else $error("bit moved");
  idle_line_zero_a: assert property (
    xfer_req_n [*8] |-> cmd_data_n) else $error("line not zero");
  ack_needs_req_a: assert property (
    $fell(xfer_ack_n) |-> !xfer_req_n) else $error("ack without req");
  req_waits_ack_a: assert property (
    $fell(xfer_req_n) |-> $past(xfer_ack_n)) else $error("req early");
  no_unasked_ack_a: assert property (
    xfer_req_n && xfer_ack_n |=> xfer_ack_n) else $error("stray ack");
  start_on_done_a: assert property (
    $fell(xfer_req_n) |-> !op_done_n) else $error("req while busy");
endmodule

// *** tb/test_disk_serial_cmd_control.sv ***
// Bench joining host and drive ends over the control-cable interface.
// Assumes design files and the checker are compiled before it.
`timescale 1ns/1ps
module test_disk_serial_cmd_control;
  import dsc_pkg::*;
  logic        ref_clk_i, arst_n_i, cmd_valid_i, wr_en_i, rd_en_i;
  logic        busy_i, media_rd_i, cmd_busy_o, cmd_done_o;
  logic        head_removable_o, write_on_o, splice_o, read_on_o;
  logic        rd_data_o, write_fault_o, seek_o, recal_o, ctrl_o;
  logic        self_check_cmd_o, sector_size_cmd_o, invalid_o;
  logic [15:0] cmd_word_i, w;
  logic [3:0]  head_i, strobe_off_o, track_off_o, ctrl_op_o;
  logic [7:0]  head_o;
  logic [11:0] cylinder_o, sector_size_o;
  logic [15:0] note_q[$];
  int          fail_count, checks, splices;
  integer      seed;
  dsc_link_if link ();
  dsc_host i_dsc_host (.ref_clk_i, .arst_n_i, .clk_en_i(1'b1), .cmd_valid_i,
    .cmd_word_i, .head_i, .wr_en_i, .rd_en_i, .cmd_busy_o, .cmd_done_o,
    .link(link.host));
  dsc_drive #(.HEADS_FITTED(8'h14), .REMOVABLE(1'b1)) i_dsc_drive (
    .ref_clk_i, .arst_n_i, .clk_en_i(1'b1), .busy_i, .media_rd_i,
    .link(link.drive), .head_o, .head_removable_o, .write_on_o, .splice_o,
    .read_on_o, .rd_data_o, .write_fault_o, .cylinder_o, .seek_o, .recal_o,
    .strobe_off_o, .track_off_o, .ctrl_op_o, .ctrl_o, .self_check_cmd_o,
    .sector_size_cmd_o, .sector_size_o, .invalid_o);
  dsc_link_properties i_dsc_link_properties (.ref_clk_i, .arst_n_i,
    .head_sel_n(link.head_sel_n), .wr_en_n(link.wr_en_n),
    .rd_en_n(link.rd_en_n), .cmd_data_n(link.cmd_data_n),
    .xfer_req_n(link.xfer_req_n), .xfer_ack_n(link.xfer_ack_n),
    .op_done_n(link.op_done_n));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic check_cmd(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) fail("decode result");
  endtask
  task automatic check_val(input logic [11:0] got, exp);
    checks++;
    if (got !== exp) fail("port value");
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      @(posedge ref_clk_i);
      #1;
      if (++n > 400) begin
        fail("timeout");
        complete_run;
      end
    end
  endtask

  // Kind E means the command leaves no decode pulse to compare.
  function automatic logic [15:0] expect_of(input logic [15:0] c);
    logic [3:0] m;
    m = c[11:8];
    case (c[15:12])
      4'h0, 4'h9: return c;
      4'h1: return 16'h1000;
      4'h5: return (m == 4'h1 || m[3:2] != 2'b00) ? 16'hF000
                   : {8'h50, 4'h0, m};
      4'h6, 4'h7: return m[3] ? 16'hF000 : 16'hE000;
      4'h8: return 16'h8000;
      4'h2, 4'h3, 4'h4: return 16'hE000;
      default: return 16'hF000;
    endcase
  endfunction

  task automatic send(input logic [15:0] c);
    logic [15:0] e;
    e = expect_of(c);
    if (e[15:12] != 4'hE) note_q.push_back(e);
    @(posedge ref_clk_i);
    cmd_word_i <= c;
    cmd_valid_i <= 1'b1;
    wait_for(cmd_busy_o, 1'b1);
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    wait_for(cmd_done_o, 1'b1);
    repeat (8) @(posedge ref_clk_i);
  endtask

  always @(negedge ref_clk_i) begin
    if (splice_o === 1'b1) splices++;
    if ((seek_o | recal_o | ctrl_o | self_check_cmd_o | sector_size_cmd_o
         | invalid_o) === 1'b1) begin
      if (note_q.size() == 0) fail("unexpected decode");
      else check_cmd(seek_o ? {4'h0, cylinder_o} : recal_o ?
        {4'h1, cylinder_o} : ctrl_o ? {8'h50, ctrl_op_o} :
        self_check_cmd_o ? 16'h8000 : sector_size_cmd_o ?
        {4'h9, sector_size_o} : 16'hF000, note_q.pop_front());
    end
  end

  initial begin
    seed = 32'hb93a;
    {cmd_valid_i, wr_en_i, rd_en_i, busy_i, media_rd_i} = 5'h00;
    cmd_word_i = 16'h0000;
    head_i = 4'h0;
    arst_n_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    check_val({4'h0, head_o}, 12'h000);
    check_val({11'h0, head_removable_o}, 12'h001);
    busy_i <= 1'b1;
    // The host sees a busy drive only after its two-flop synchroniser.
    repeat (4) @(posedge ref_clk_i);
    cmd_word_i <= 16'h1000;
    cmd_valid_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    check_val({11'h0, cmd_busy_o}, 12'h000);
    cmd_valid_i <= 1'b0;
    busy_i <= 1'b0;
    $display("test refusal done");
    for (int f = 0; f < 16; f++) begin
      w = {4'(f), 12'($random(seed))};
      if (f != 0 && f != 9) w[7:0] = 8'h00;
      if (f == 1 || f == 8) w[11:8] = 4'h0;
      if (f != 4) send(w);
    end
    send(16'h6500);
    send(16'h7300);
    check_val({4'h0, strobe_off_o, track_off_o}, 12'h053);
    send({4'h0, 12'($random(seed))});
    check_val({4'h0, strobe_off_o, track_off_o}, 12'h000);
    send(16'h7600);
    send(16'h6200);
    check_val({4'h0, strobe_off_o, track_off_o}, 12'h026);
    send(16'h1000);
    check_val({4'h0, strobe_off_o, track_off_o}, 12'h000);
    $display("test commands done");
    send(16'h4010);
    head_i <= 4'h3;
    wr_en_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    check_val({4'h0, head_o}, 12'h013);
    check_val({10'h0, write_on_o, write_fault_o}, 12'h002);
    check_val(12'(splices), 12'h001);
    head_i <= 4'h5;
    repeat (8) @(posedge ref_clk_i);
    check_val({10'h0, head_removable_o, write_fault_o}, 12'h001);
    wr_en_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    check_val({10'h0, write_on_o, write_fault_o}, 12'h000);
    wr_en_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    check_val(12'(splices), 12'h002);
    wr_en_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    $display("test write gate done");
    // Read stays off while the write gate is on, as a host must do.
    rd_en_i <= 1'b1;
    media_rd_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    check_val({10'h0, read_on_o, rd_data_o}, 12'h003);
    rd_en_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    check_val({10'h0, read_on_o, rd_data_o}, 12'h000);
    $display("test read gate done");
    if (note_q.size() != 0) fail("missing decode");
    complete_run;
  end
endmodule
